// >>> hw/circ_defines.vh
`ifndef CIRC_DEFINES_VH
`define CIRC_DEFINES_VH
// ****************************************
// timing
// ****************************************
`define CLK_HZ          100000000
`define CYC_PER_MS      (`CLK_HZ/1000)
`define DEB_MS_MIN      7'h01
`define DEB_MS_MAX      7'h64
`define DEB_MS_RST      7'h0a
`define PW_MS_MIN       10'h00a
`define PW_MS_MAX       10'h3e8
`define PW_MS_RST       10'h064
`define HALF_CYC_RST    16'h000a
// ****************************************
// relay modes
// ****************************************
`define MODE_UNLATCHED  2'h0
`define MODE_LATCHED    2'h1
`define MODE_PULSE      2'h2
`define MODE_TOGGLE     2'h3
// ****************************************
// energy sources
// ****************************************
`define SRC_NONE        3'h0
`define SRC_ACT_IMP     3'h1
`define SRC_ACT_EXP     3'h2
`define SRC_ACT_TOT     3'h3
`define SRC_REA_IMP     3'h4
`define SRC_REA_EXP     3'h5
`define SRC_REA_TOT     3'h6
`define SRC_APP_TOT     3'h7
// weight in thousandths of a unit: 1 .. 1000000, default 1000
`define WEIGHT_RST      20'h003e8
`endif

// >>> hw/contact_input_relay_output_ctrl.v
// What this block does
// - single-edge mode: one event per pulse
// - transition mode: event on both edges
// - normal polarity counts open to closed
// - inverting polarity counts closed to open
// - polarity ignored in transition mode
// - accept state after stable debounce time
// - one debounce value shared by all inputs
// - relay from setpoint, remote or pulse source
// - unlatched: active exactly while setpoint active
// - latched: set by setpoint, cleared by other
// - pulse: active width, inactive width, stay off
// - toggle: invert on every command
// - normal polarity: energized while active
// - inverting polarity: energized while inactive
// - retention only for latched, default off
// - retention off: inactive at power up
// - retention on: restore latched state
// - width rounded up to half cycles
// - pause between pulses at least width
// - energy source linked in pulse/toggle only
// - programmable energy weight per pulse
`timescale 1ns/1ns
`include "circ_defines.vh"
module contact_input_relay_output_ctrl #(
   parameter N_IN  = 8,
   parameter N_OUT = 7,
   // clocks per millisecond; a bench may shrink it to keep runs short
   parameter CYC_PER_MS = `CYC_PER_MS
) (
   // clock and reset
   input  wire                 clk_sys,
   input  wire                 srst,
   // contact side
   input  wire [N_IN-1:0]      contact_in,
   input  wire [N_IN-1:0]      both_edge_transition_mode,
   input  wire [N_IN-1:0]      in_invert,
   input  wire [6:0]           debounce_ms,
   // mains timebase and relay setup
   input  wire                 half_cycle_tick,
   input  wire [N_OUT*2-1:0]   relay_mode,
   input  wire [N_OUT-1:0]     relay_invert,
   input  wire [N_OUT-1:0]     relay_retain,
   input  wire [N_OUT*10-1:0]  pulse_ms,
   input  wire [15:0]          half_cycle_cycles,
   // relay commands
   input  wire [N_OUT-1:0]     setpoint_active,
   input  wire [N_OUT-1:0]     setpoint_set,
   input  wire [N_OUT-1:0]     setpoint_clear,
   input  wire [N_OUT-1:0]     remote_set,
   input  wire [N_OUT-1:0]     remote_clear,
   input  wire [N_OUT-1:0]     remote_cmd,
   input  wire [N_OUT*3-1:0]   pulse_source,
   input  wire [N_OUT*20-1:0]  energy_weight,
   // internal energy events
   input  wire                 active_import_energy_pulse,
   input  wire                 active_export_energy_pulse,
   input  wire                 active_total_energy_pulse,
   input  wire                 reactive_import_energy_pulse,
   input  wire                 reactive_export_energy_pulse,
   input  wire                 reactive_total_energy_pulse,
   input  wire                 apparent_total_energy_pulse,
   // retention store
   input  wire [N_OUT-1:0]     retained_state,
   input  wire                 restore,
   // status and coil outputs
   output reg  [N_IN-1:0]      in_state,
   output reg  [N_IN-1:0]      in_event,
   output reg  [N_OUT-1:0]     relay_active,
   output reg  [N_OUT-1:0]     coil_drive
);

// ****************************************
// shared debounce tick
// ****************************************
// clamp to the allowed range so a bad setting cannot stall inputs
reg  [6:0] deb_ms;
always @* begin
   if (debounce_ms < `DEB_MS_MIN)
      deb_ms = `DEB_MS_MIN;
   else if (debounce_ms > `DEB_MS_MAX)
      deb_ms = `DEB_MS_MAX;
   else
      deb_ms = debounce_ms;
end
reg  [16:0] ms_div;
reg         ms_tick;
// count wraps once a millisecond; cut on purpose to the divider width
localparam integer MS_LAST_I = CYC_PER_MS - 1;
localparam [16:0] MS_LAST = MS_LAST_I[16:0];

// millisecond prescaler for every input
always @(posedge clk_sys) begin
   if (srst) begin
      ms_div  <= 17'h00000;
      ms_tick <= 1'b0;
   end else begin
      ms_tick <= (ms_div == MS_LAST);
      ms_div  <= (ms_div == MS_LAST) ? 17'h00000 : ms_div + 17'h00001;
   end
end

// ****************************************
// contact inputs
// ****************************************
// one channel per contact input
genvar gi;
generate
for (gi = 0; gi < N_IN; gi = gi + 1) begin : g_in
   reg [2:0] sync;
   reg [6:0] stable_ms;
   // hold the old level while the last two sync stages disagree
   wire      raw = (sync[1] == sync[2]) ? sync[2] : in_state[gi];
   // a change only counts once the timer has reached the debounce
   wire      rise = (stable_ms >= deb_ms) && raw && !in_state[gi];
   wire      fall = (stable_ms >= deb_ms) && !raw && in_state[gi];
   // three-stage sync, then stability timer on the settled value
   always @(posedge clk_sys) begin
      if (srst) begin
         sync         <= 3'h0;
         stable_ms    <= 7'h00;
         in_state[gi] <= 1'b0;
         in_event[gi] <= 1'b0;
      end else begin
         sync <= {sync[1:0], contact_in[gi]};
         if (raw == in_state[gi])
            stable_ms <= 7'h00;
         else if (ms_tick && stable_ms < deb_ms)
            stable_ms <= stable_ms + 7'h01;
         if (rise || fall)
            in_state[gi] <= raw;
         // polarity only matters for single-edge
         if (both_edge_transition_mode[gi])
            in_event[gi] <= rise | fall;
         else if (in_invert[gi])
            in_event[gi] <= fall;
         else
            in_event[gi] <= rise;
      end
   end
end
endgenerate

// ****************************************
// relay outputs
// ****************************************
// pulse sequencer states, one-hot
localparam ST_IDLE  = 3'b001;
localparam ST_ON    = 3'b010;
localparam ST_PAUSE = 3'b100;

// pick the energy event for a source code
function src_pick;
   input [2:0] s;
   begin
      case (s)
         `SRC_ACT_IMP: src_pick = active_import_energy_pulse;
         `SRC_ACT_EXP: src_pick = active_export_energy_pulse;
         `SRC_ACT_TOT: src_pick = active_total_energy_pulse;
         `SRC_REA_IMP: src_pick = reactive_import_energy_pulse;
         `SRC_REA_EXP: src_pick = reactive_export_energy_pulse;
         `SRC_REA_TOT: src_pick = reactive_total_energy_pulse;
         `SRC_APP_TOT: src_pick = apparent_total_energy_pulse;
         default:      src_pick = 1'b0;
      endcase
   end
endfunction

// half cycles needed for a width in ms, rounded up
function [15:0] half_cycles;
   input [9:0]  ms;
   input [15:0] hc_ms;
   reg   [9:0]  w;
   reg   [15:0] h;
   begin
      w = (ms < `PW_MS_MIN) ? `PW_MS_MIN :
          (ms > `PW_MS_MAX) ? `PW_MS_MAX : ms;
      h = (hc_ms == 16'h0000) ? 16'h0001 : hc_ms;
      half_cycles = ({6'h00, w} + h - 16'h0001) / h;
   end
endfunction

// half-cycle period in ms, from the cycle count of the mains timebase
wire [15:0] hc_ms = half_cycle_cycles;

// one channel per relay output
genvar go;
generate
for (go = 0; go < N_OUT; go = go + 1) begin : g_out
   // per-relay slices of the packed setup ports
   wire [1:0]  mode = relay_mode[go*2 +: 2];
   wire [2:0]  src  = pulse_source[go*3 +: 3];
   wire [19:0] wt   = energy_weight[go*20 +: 20];
   wire [20:0] wt_c = (wt == 20'h00000) ? 21'h000001 : {1'b0, wt};
   wire        is_pt = (mode == `MODE_PULSE) || (mode == `MODE_TOGGLE);
   // weight in thousandths; each source event is one thousandth
   wire        e_in = is_pt && (src != `SRC_NONE) && src_pick(src);
   reg  [20:0] acc;
   wire [20:0] acc_n = acc + 21'h000001;
   wire        e_cmd = e_in && (acc_n >= wt_c);
   // any source may command the relay; the mode decides the effect
   wire        cmd = remote_cmd[go] | setpoint_set[go] | e_cmd;
   // pulse sequencer: on time, forced pause, queued command
   reg  [2:0]  st;
   reg  [15:0] hc_left;
   reg         pend;
   wire [15:0] width = half_cycles(pulse_ms[go*10 +: 10], hc_ms);

   // ****************************************
   // energy pulse command
   // ****************************************
   // energy accumulator with carry of remainder
   always @(posedge clk_sys) begin
      if (srst)
         acc <= 21'h000000;
      else if (e_in)
         acc <= e_cmd ? acc_n - wt_c : acc_n;
   end

   // ****************************************
   // relay state
   // ****************************************
   // relay state per mode
   always @(posedge clk_sys) begin
      if (srst) begin
         st                <= ST_IDLE;
         hc_left           <= 16'h0000;
         pend              <= 1'b0;
         // power-up state: every relay inactive; restore later reloads retained latched relays
         relay_active[go]  <= 1'b0;
         coil_drive[go]    <= 1'b0;
      end else begin
         // coil follows one cycle behind the logical state
         coil_drive[go] <= relay_active[go] ^ relay_invert[go];
         // restore wins over commands in the same cycle
         if (restore && relay_retain[go] && mode == `MODE_LATCHED)
            relay_active[go] <= retained_state[go];
         else begin
            case (mode)
               `MODE_UNLATCHED:
                  relay_active[go] <= setpoint_active[go];
               `MODE_LATCHED: begin
                  if (setpoint_set[go] | remote_set[go])
                     relay_active[go] <= 1'b1;
                  else if (setpoint_clear[go] | remote_clear[go])
                     relay_active[go] <= 1'b0;
               end
               `MODE_TOGGLE: begin
                  if (cmd)
                     relay_active[go] <= ~relay_active[go];
               end
               default: begin
                  // commands during a pulse wait for the pause to end
                  if (cmd && st != ST_IDLE)
                     pend <= 1'b1;
                  case (st)
                     ST_IDLE: begin
                        // idle keeps the relay off between pulses
                        relay_active[go] <= 1'b0;
                        if (cmd || pend) begin
                           pend             <= 1'b0;
                           st               <= ST_ON;
                           hc_left          <= width;
                           relay_active[go] <= 1'b1;
                        end
                     end
                     ST_ON: begin
                        // whole half cycles; the tick is the only time base
                        if (half_cycle_tick) begin
                           if (hc_left <= 16'h0001) begin
                              st               <= ST_PAUSE;
                              hc_left          <= width;
                              relay_active[go] <= 1'b0;
                           end else
                              hc_left <= hc_left - 16'h0001;
                        end
                     end
                     ST_PAUSE: begin
                        // one more full width must pass before a new pulse
                        if (half_cycle_tick) begin
                           if (hc_left <= 16'h0001)
                              st <= ST_IDLE;
                           else
                              hc_left <= hc_left - 16'h0001;
                        end
                     end
                     default: st <= ST_IDLE;
                  endcase
               end
            endcase
            // leaving pulse mode in ST_ON or ST_PAUSE drops a queued command as well, so a
            // later return to pulse mode starts clean
            if (mode != `MODE_PULSE && st != ST_IDLE) begin
               st   <= ST_IDLE;
               pend <= 1'b0;
            end
         end
      end
   end
end
endgenerate

endmodule // contact_input_relay_output_ctrl

// >>> tb/circ_props.sv
`timescale 1ns/1ns
// ****************************************
// relay port checker
// ****************************************
module circ_props #(
   parameter N_OUT = 7
) (
   input wire               clk_sys,
   input wire               srst,
   input wire [N_OUT*2-1:0] relay_mode,
   input wire [N_OUT-1:0]   relay_invert,
   input wire [N_OUT-1:0]   relay_retain,
   input wire [N_OUT-1:0]   setpoint_active,
   input wire [N_OUT-1:0]   setpoint_set,
   input wire [N_OUT-1:0]   setpoint_clear,
   input wire [N_OUT-1:0]   remote_clear,
   input wire [N_OUT-1:0]   remote_cmd,
   input wire [N_OUT-1:0]   retained_state,
   input wire               restore,
   input wire [N_OUT-1:0]   relay_active,
   input wire [N_OUT-1:0]   coil_drive
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   // coil lags the state by a cycle; reset edge skipped
   chk_coil_follow: assert property (
      !$past(srst) |-> coil_drive == $past(relay_active ^ relay_invert))
      else $error("coil drive wrong");
   chk_unlatch_follow: assert property (
      relay_mode[1:0] == 2'h0 && $stable(relay_mode[1:0]) && !$past(srst)
      |-> relay_active[0] == $past(setpoint_active[0]))
      else $error("unlatched relay off its setpoint");
   chk_toggle_flip: assert property (
      relay_mode[7:6] == 2'h3 && remote_cmd[3]
      |=> relay_active[3] != $past(relay_active[3]))
      else $error("toggle relay kept its state");
   chk_latch_set: assert property (
      relay_mode[3:2] == 2'h1 && setpoint_set[1] && !restore
      |=> relay_active[1])
      else $error("latched relay not set");
   chk_latch_clear: assert property (
      relay_mode[3:2] == 2'h1 && remote_clear[1] && !setpoint_set[1]
      && !restore |=> !relay_active[1])
      else $error("latched relay not cleared");
   // without a clear or a restore the latch must hold, whatever else moves
   chk_latch_hold: assert property (
      relay_mode[3:2] == 2'h1 && relay_active[1] && !setpoint_clear[1]
      && !remote_clear[1] && !restore |=> relay_active[1])
      else $error("latched relay dropped");
   chk_reset_idle: assert property (disable iff (1'b0)
      srst |=> relay_active == '0 && coil_drive == '0)
      else $error("relay active after reset");
   chk_retain_load: assert property (
      restore && relay_mode[13:12] == 2'h1 && relay_retain[6]
      |=> relay_active[6] == $past(retained_state[6]))
      else $error("retained state not restored");
endmodule // circ_props

// >>> tb/field_model.sv
`timescale 1ns/1ns
// ****************************************
// dry contacts and coil drivers
// ****************************************
module field_model (
   input  wire       clk_sys,
   input  wire [6:0] coil_drive,
   output reg  [7:0] contact_in
);
   integer       coil_pulls = 0;
   reg     [6:0] coil_last = 7'h00;
   // contacts rest open, so inputs idle at the open level
   initial contact_in = 8'h00;
   // contacts change at an edge through a nonblocking write, after that edge has sampled them
   task drive(input [7:0] v);
      begin
         @(posedge clk_sys);
         contact_in <= v;
      end
   endtask
   // count pull-ins of relay 3, as an external counter would
   always @(posedge clk_sys) begin
      coil_last <= coil_drive;
      if (coil_drive[3] && !coil_last[3])
         coil_pulls <= coil_pulls + 1;
   end
endmodule // field_model

// >>> tb/testbench.sv
`timescale 1ns/1ns
module testbench;
   reg          clk_sys = 1'b0, srst = 1'b1, half_cycle_tick = 1'b0;
   reg          restore = 1'b0;
   reg  [6:0]   setpoint_active = 7'h00, setpoint_set = 7'h00;
   reg  [6:0]   setpoint_clear = 7'h00, remote_set = 7'h00;
   reg  [6:0]   remote_clear = 7'h00, remote_cmd = 7'h00, epulse = 7'h00;
   reg  [6:0]   relay_invert = 7'h02, relay_retain = 7'h40;
   reg  [6:0]   retained_state = 7'h43;
   reg  [13:0]  relay_mode = 14'h17e4;
   reg  [20:0]  pulse_source = 21'h009000;
   reg  [7:0]   in_both = 8'h02, in_inv = 8'h06;
   wire [7:0]   contact_in, in_state, in_event;
   integer      ev0 = 0, ev1 = 0, ev2 = 0;
   wire [6:0]   relay_active, coil_drive;
   integer      err_total = 0, checks_done = 0, tcnt = 0;
   // ****************************************
   // clock, half-cycle timebase, instances
   // ****************************************
   always #5 clk_sys = ~clk_sys;
   // a tick every 4 clocks keeps pulse widths short
   always @(posedge clk_sys) begin
      tcnt <= (tcnt == 3) ? 0 : tcnt + 1;
      half_cycle_tick <= (tcnt == 3);
   end
   // event tallies per input, for the contact scenario
   always @(posedge clk_sys) begin
      if (!srst) begin
         ev0 <= ev0 + in_event[0];
         ev1 <= ev1 + in_event[1];
         ev2 <= ev2 + in_event[2];
      end
   end
   // a 10-clock millisecond keeps debounce runs short
   contact_input_relay_output_ctrl #(.CYC_PER_MS(10)) DUT (.clk_sys, .srst,
      .contact_in, .both_edge_transition_mode(in_both), .in_invert(in_inv),
      .debounce_ms(7'h02), .half_cycle_tick, .relay_mode, .relay_invert,
      .relay_retain, .pulse_ms({7{10'h015}}), .half_cycle_cycles(16'h000a),
      .setpoint_active, .setpoint_set, .setpoint_clear, .remote_set,
      .remote_clear, .remote_cmd, .pulse_source,
      .energy_weight({7{20'h00003}}), .retained_state, .restore,
      .active_import_energy_pulse(epulse[0]),
      .active_export_energy_pulse(epulse[1]),
      .active_total_energy_pulse(epulse[2]),
      .reactive_import_energy_pulse(epulse[3]),
      .reactive_export_energy_pulse(epulse[4]),
      .reactive_total_energy_pulse(epulse[5]),
      .apparent_total_energy_pulse(epulse[6]),
      .in_state, .in_event, .relay_active, .coil_drive);
   field_model FIELD (.clk_sys, .coil_drive, .contact_in);
   // ****************************************
   // shared helpers
   // ****************************************
   task check(input [31:0] seen, input [31:0] exp);
      begin
         checks_done = checks_done + 1;
         if (seen !== exp) begin
            err_total = err_total + 1;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task step(input integer n);
      begin
         repeat (n) @(posedge clk_sys);
         #1;
      end
   endtask
   task send_energy(input [6:0] which, input integer n);
      begin
         repeat (n) begin
            @(posedge clk_sys) epulse <= which;
            @(posedge clk_sys) epulse <= 7'h00;
         end
         step(3);
      end
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task t_inputs;
      integer a0, a1, a2;
      begin
         a0 = ev0;
         a1 = ev1;
         a2 = ev2;
         // a closure shorter than the debounce must be ignored
         FIELD.drive(8'h01);
         step(4);
         FIELD.drive(8'h00);
         step(40);
         check(in_state[0], 1'b0);
         check(ev0 - a0, 0);
         FIELD.drive(8'h07);
         step(40);
         check(in_state[2:0], 3'h7);
         check(ev0 - a0, 1);
         check(ev1 - a1, 1);
         check(ev2 - a2, 0);
         FIELD.drive(8'h00);
         step(40);
         check(in_state[2:0], 3'h0);
         check(ev0 - a0, 1);
         check(ev1 - a1, 2);
         check(ev2 - a2, 1);
         $display("input test done");
      end
   endtask
   task t_modes;
      integer base;
      begin
         base = FIELD.coil_pulls;
         check(coil_drive[1], 1'b1);
         @(posedge clk_sys) setpoint_active <= 7'h01;
         setpoint_set <= 7'h02;
         remote_cmd <= 7'h08;
         @(posedge clk_sys) setpoint_active <= 7'h00;
         setpoint_set <= 7'h00;
         remote_cmd <= 7'h00;
         #1;
         check(relay_active & 7'h0b, 7'h0b);
         step(6);
         check({relay_active & 7'h0b, coil_drive[1]}, 8'h14);
         @(posedge clk_sys) remote_clear <= 7'h02;
         remote_cmd <= 7'h08;
         @(posedge clk_sys) remote_clear <= 7'h00;
         remote_cmd <= 7'h00;
         step(2);
         check({relay_active & 7'h0b, coil_drive[1]}, 8'h01);
         check(FIELD.coil_pulls - base, 1);
         $display("mode test done");
      end
   endtask
   task t_pulse;
      integer on, off;
      begin
         on = 0;
         off = 0;
         while (half_cycle_tick !== 1'b1) step(1);
         @(posedge clk_sys) remote_cmd <= 7'h04;
         @(posedge clk_sys) remote_cmd <= 7'h00;
         #1;
         while (relay_active[2] === 1'b1 && on < 40) begin
            step(1);
            on = on + 1;
         end
         // second command lands in the pause and must wait
         @(posedge clk_sys) remote_cmd <= 7'h04;
         @(posedge clk_sys) remote_cmd <= 7'h00;
         #1;
         while (relay_active[2] !== 1'b1 && off < 40) begin
            step(1);
            off = off + 1;
         end
         check(on >= 10 && on <= 13, 1'b1);
         check(off >= 9 && off <= 16, 1'b1);
         step(40);
         check(relay_active[2], 1'b0);
         $display("pulse test done");
      end
   endtask
   task t_energy;
      integer k;
      reg     exp;
      begin
         exp = 1'b0;
         for (k = 1; k <= 7; k = k + 1) begin
            @(posedge clk_sys) pulse_source[14:12] <= k[2:0];
            send_energy(7'h01 << (k % 7), 3);
            check(relay_active[4], exp);
            send_energy(7'h01 << (k - 1), 3);
            exp = ~exp;
            check(relay_active[4], exp);
         end
         send_energy(7'h40, 2);
         check(relay_active[5:4], {1'b0, exp});
         send_energy(7'h40, 1);
         check(relay_active[4], !exp);
         $display("energy test done");
      end
   endtask
   task t_retain;
      begin
         @(posedge clk_sys) srst <= 1'b1;
         step(3);
         check(relay_active, 7'h00);
         @(posedge clk_sys) srst <= 1'b0;
         @(posedge clk_sys) restore <= 1'b1;
         @(posedge clk_sys) restore <= 1'b0;
         step(1);
         check(relay_active, 7'h40);
         $display("retention test done");
      end
   endtask
   task summarize;
      begin
         $display("checks %0d mismatches %0d", checks_done, err_total);
         if (err_total == 0 && checks_done > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   // watchdog: the tests need about 380 clocks
   initial begin
      #100000;
      err_total = err_total + 1;
      summarize;
   end
   initial begin
      repeat (10) @(posedge clk_sys);
      srst <= 1'b0;
      step(2);
      t_inputs;
      t_modes;
      t_pulse;
      t_energy;
      t_retain;
      summarize;
   end
endmodule // testbench
bind contact_input_relay_output_ctrl circ_props #(.N_OUT(N_OUT)) u_props (
   .clk_sys, .srst, .relay_mode, .relay_invert, .relay_retain,
   .setpoint_active, .setpoint_set, .setpoint_clear, .remote_clear,
   .remote_cmd, .retained_state, .restore, .relay_active, .coil_drive);
